/* File: common/spbc_consts.svh */
// Purpose: Constants for the boot-configuration strap capture block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Included by bare name.
`ifndef SPBC_CONSTS_SVH
`define SPBC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SPBC_OFS_STRAP      12'h000
`define SPBC_OFS_DECODE     12'h004
`define SPBC_OFS_OVERRIDE   12'h008

// ----------------------------------------------------------------------
// Strap bit positions in the strap-value register
// ----------------------------------------------------------------------
`define SPBC_BIT_LDO        0
`define SPBC_BIT_BOOT       1
`define SPBC_BIT_QUAL       2
`define SPBC_BIT_LOG        3
`define SPBC_BIT_SDIO       4

// ----------------------------------------------------------------------
// Override register fields
// ----------------------------------------------------------------------
`define SPBC_OVR_LDO_EN     0
`define SPBC_OVR_LDO_VAL    1
`define SPBC_OVR_SDIO_EN    2
`define SPBC_OVR_SAMPLE     3
`define SPBC_OVR_OUTPUT     4

// ----------------------------------------------------------------------
// Decode register fields
// ----------------------------------------------------------------------
`define SPBC_DEC_LDO        0
`define SPBC_DEC_BOOT_LO    1
`define SPBC_DEC_BOOT_HI    2
`define SPBC_DEC_LOG        3
`define SPBC_DEC_SAMPLE     4
`define SPBC_DEC_OUTPUT     5
`define SPBC_DEC_CAPTURED   6

// ----------------------------------------------------------------------
// Reset values and pull defaults (1 = pull-up, 0 = pull-down)
// ----------------------------------------------------------------------
`define SPBC_PULL_DEFAULT   5'h1A
`define SPBC_STRAP_RST      5'h00
`define SPBC_OVR_RST        5'h00

`endif

/* File: common/spbc_pkg.sv */
// Purpose: Types for the boot-configuration strap capture block.
// Assumes: Nothing beyond the constants header.
// Notes:   Boot mode codes are the field in the decode register.
package spbc_pkg;

   typedef enum logic [1:0] {
      SPBC_BOOT_DOWNLOAD = 2'h0,
      SPBC_BOOT_FLASH    = 2'h1,
      SPBC_BOOT_UNDEF    = 2'h2
   } spbc_boot_t;

   typedef enum logic [2:0] {
      SPBC_ST_RESET   = 3'b001,
      SPBC_ST_CAPTURE = 3'b010,
      SPBC_ST_RUN     = 3'b100
   } spbc_state_t;

endpackage : spbc_pkg

/* File: logic/spbc_pad_ctrl.sv */
// Purpose: Strap pad control: weak pulls during reset, function mux after.
// Assumes: Pulls are modelled as enable bits for the pad cells.
// Notes:   Outputs are registered.
`timescale 1ns/1ps
`include "spbc_consts.svh"

module spbc_pad_ctrl #(
   parameter int N = 5
) (
   // Clock and reset
   input  wire logic         clock_in,
   input  wire logic         rst_n_in,
   // Phase
   input  wire logic         in_reset_in,
   // Function side
   input  wire logic [N-1:0] func_out_in,
   input  wire logic [N-1:0] func_oe_in,
   // Pad side
   output logic      [N-1:0] pull_up_en_out,
   output logic      [N-1:0] pull_dn_en_out,
   output logic      [N-1:0] pad_out,
   output logic      [N-1:0] pad_oe_out
);

   localparam logic [N-1:0] PULL_DEF = N'(`SPBC_PULL_DEFAULT);

   // ----------------------------------------------------------------------
   // Pull enables during reset, ordinary drive afterwards
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pull_up_en_out <= PULL_DEF;
         pull_dn_en_out <= ~PULL_DEF;
         pad_out        <= '0;
         pad_oe_out     <= '0;
      end else if (in_reset_in) begin
         pull_up_en_out <= PULL_DEF;
         pull_dn_en_out <= ~PULL_DEF;
         pad_out        <= '0;
         pad_oe_out     <= '0;
      end else begin
         pull_up_en_out <= '0;
         pull_dn_en_out <= '0;
         pad_out        <= func_out_in;
         pad_oe_out     <= func_oe_in;
      end
   end

endmodule : spbc_pad_ctrl

/* File: logic/spbc_strap_latch.sv */
// Purpose: Captures the strap pins once and holds them.
// Assumes: Pins are synchronous to the clock.
// Notes:   Only a new reset of the power domain lets it capture again.
`timescale 1ns/1ps
`include "spbc_consts.svh"

module spbc_strap_latch #(
   parameter int N = 5
) (
   // Clock and reset
   input  wire logic         clock_in,
   input  wire logic         rst_n_in,
   // Capture control
   input  wire logic         capture_in,
   input  wire logic [N-1:0] pins_in,
   // Held value
   output logic      [N-1:0] straps_out,
   output logic              captured_out
);

   // ----------------------------------------------------------------------
   // One-shot capture
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         straps_out   <= N'(`SPBC_STRAP_RST);
         captured_out <= 1'b0;
      end else if (capture_in && !captured_out) begin
         straps_out   <= pins_in;
         captured_out <= 1'b1;
      end
   end

endmodule : spbc_strap_latch

/* File: logic/spbc_top.sv */
// Purpose: Boot-configuration strap capture with APB register access.
// Assumes: One 100 MHz clock; pins synchronous; reset sources combined
//          into nrst_in outside.
// Notes:   Strap order in vectors: ldo, boot, qualify, log, sdio.
`timescale 1ns/1ps
`include "spbc_consts.svh"

module spbc_top #(
   parameter int N = 5
) (
   // Clock and reset
   input  wire logic         clock_in,
   input  wire logic         nrst_in,
   // Module enable
   input  wire logic         module_enable_in,
   // Strap pins
   input  wire logic         ldo_voltage_strap_in,
   input  wire logic         boot_select_strap_in,
   input  wire logic         download_qualify_strap_in,
   input  wire logic         log_and_timing_strap_in,
   input  wire logic         sdio_timing_strap_in,
   // Function drive for the strap pads after boot
   input  wire logic [N-1:0] func_out_in,
   input  wire logic [N-1:0] func_oe_in,
   // Pad control
   output logic      [N-1:0] pull_up_en_out,
   output logic      [N-1:0] pull_dn_en_out,
   output logic      [N-1:0] pad_out,
   output logic      [N-1:0] pad_oe_out,
   // Decoded configuration
   output logic              ldo_1v8_sel_out,
   output logic              boot_flash_out,
   output logic              boot_download_out,
   output logic              boot_log_tx_line_en_out,
   output logic              sdio_sample_rise_out,
   output logic              sdio_output_rise_out,
   output logic              config_valid_out,
   // APB slave
   input  wire logic         psel_in,
   input  wire logic         penable_in,
   input  wire logic         pwrite_in,
   input  wire logic [11:0]  paddr_in,
   input  wire logic [31:0]  pwdata_in,
   input  wire logic [3:0]   pstrb_in,
   output logic      [31:0]  prdata_out,
   output logic              pready_out,
   output logic              pslverr_out
);

   // ----------------------------------------------------------------------
   // Reset synchroniser
   // ----------------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n_r;

   // Release is held back two edges so that every flop leaves reset on the
   // same edge, clear of the asynchronous release.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------------
   // Phase sequencer
   // ----------------------------------------------------------------------
   spbc_pkg::spbc_state_t state_r;
   spbc_pkg::spbc_state_t state_nxt;

   // Capture waits for the enable, so no strap is sampled before it is set.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         spbc_pkg::SPBC_ST_RESET: begin
            if (module_enable_in) begin
               state_nxt = spbc_pkg::SPBC_ST_CAPTURE;
            end
         end
         spbc_pkg::SPBC_ST_CAPTURE: begin
            state_nxt = spbc_pkg::SPBC_ST_RUN;
         end
         spbc_pkg::SPBC_ST_RUN: begin
            state_nxt = spbc_pkg::SPBC_ST_RUN;
         end
         default: begin
            state_nxt = spbc_pkg::SPBC_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= spbc_pkg::SPBC_ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   wire logic capture    = (state_r == spbc_pkg::SPBC_ST_CAPTURE);
   wire logic in_reset   = (state_r != spbc_pkg::SPBC_ST_RUN);

   // ----------------------------------------------------------------------
   // Strap latch and pad control
   // ----------------------------------------------------------------------
   logic [N-1:0] pins;
   logic [N-1:0] straps;
   logic         captured;

   // The pulls stay on through the capture cycle, so an undriven pin is
   // latched at its pulled level.
   assign pins[`SPBC_BIT_LDO]  = ldo_voltage_strap_in;
   assign pins[`SPBC_BIT_BOOT] = boot_select_strap_in;
   assign pins[`SPBC_BIT_QUAL] = download_qualify_strap_in;
   assign pins[`SPBC_BIT_LOG]  = log_and_timing_strap_in;
   assign pins[`SPBC_BIT_SDIO] = sdio_timing_strap_in;

   spbc_strap_latch #(.N(N)) u_latch (
      .clock_in     (clock_in),
      .rst_n_in     (rst_n_r),
      .capture_in   (capture),
      .pins_in      (pins),
      .straps_out   (straps),
      .captured_out (captured)
   );

   spbc_pad_ctrl #(.N(N)) u_pads (
      .clock_in       (clock_in),
      .rst_n_in       (rst_n_r),
      .in_reset_in    (in_reset),
      .func_out_in    (func_out_in),
      .func_oe_in     (func_oe_in),
      .pull_up_en_out (pull_up_en_out),
      .pull_dn_en_out (pull_dn_en_out),
      .pad_out        (pad_out),
      .pad_oe_out     (pad_oe_out)
   );

   // ----------------------------------------------------------------------
   // Override register
   // ----------------------------------------------------------------------
   // Override writes are ignored until the straps are latched, so firmware
   // can never mask a strap before it has been sampled.
   logic [4:0] override_r;

   wire logic apb_access = psel_in && penable_in;
   wire logic apb_write  = apb_access && pwrite_in;
   wire logic sel_strap  = (paddr_in == `SPBC_OFS_STRAP);
   wire logic sel_decode = (paddr_in == `SPBC_OFS_DECODE);
   wire logic sel_ovr    = (paddr_in == `SPBC_OFS_OVERRIDE);
   wire logic addr_ok    = sel_strap || sel_decode || sel_ovr;

   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         override_r <= 5'(`SPBC_OVR_RST);
      end else if (apb_write && sel_ovr && pstrb_in[0] && captured) begin
         override_r <= pwdata_in[4:0];
      end
   end

   // ----------------------------------------------------------------------
   // Decode of captured straps
   // ----------------------------------------------------------------------
   function automatic spbc_pkg::spbc_boot_t boot_mode(input logic sel, input logic qual);
      if (sel) begin
         boot_mode = spbc_pkg::SPBC_BOOT_FLASH;
      end else if (!qual) begin
         boot_mode = spbc_pkg::SPBC_BOOT_DOWNLOAD;
      end else begin
         boot_mode = spbc_pkg::SPBC_BOOT_UNDEF;
      end
   endfunction : boot_mode

   spbc_pkg::spbc_boot_t boot;
   logic                 ldo_sel;
   logic                 smp_rise;
   logic                 out_rise;

   always_comb begin
      boot     = boot_mode(straps[`SPBC_BIT_BOOT], straps[`SPBC_BIT_QUAL]);
      ldo_sel  = override_r[`SPBC_OVR_LDO_EN] ? override_r[`SPBC_OVR_LDO_VAL]
                                               : straps[`SPBC_BIT_LDO];
      smp_rise = override_r[`SPBC_OVR_SDIO_EN] ? override_r[`SPBC_OVR_SAMPLE]
                                                : straps[`SPBC_BIT_LOG];
      out_rise = override_r[`SPBC_OVR_SDIO_EN] ? override_r[`SPBC_OVR_OUTPUT]
                                                : straps[`SPBC_BIT_SDIO];
   end

   // ----------------------------------------------------------------------
   // Registered configuration outputs
   // ----------------------------------------------------------------------
   // Every output stays low until the capture is done, so nothing downstream
   // acts on the reset value of the latch.
   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ldo_1v8_sel_out <= 1'b0;
      end else begin
         ldo_1v8_sel_out <= captured && ldo_sel;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         boot_flash_out    <= 1'b0;
         boot_download_out <= 1'b0;
      end else begin
         boot_flash_out    <= captured && (boot == spbc_pkg::SPBC_BOOT_FLASH);
         boot_download_out <= captured && (boot == spbc_pkg::SPBC_BOOT_DOWNLOAD);
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         boot_log_tx_line_en_out <= 1'b0;
      end else begin
         boot_log_tx_line_en_out <= captured && straps[`SPBC_BIT_LOG];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sdio_sample_rise_out <= 1'b0;
      end else begin
         sdio_sample_rise_out <= captured && smp_rise;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sdio_output_rise_out <= 1'b0;
      end else begin
         sdio_output_rise_out <= captured && out_rise;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         config_valid_out <= 1'b0;
      end else begin
         config_valid_out <= captured && module_enable_in;
      end
   end

   // ----------------------------------------------------------------------
   // APB read path, zero wait states
   // ----------------------------------------------------------------------
   // Unmapped offsets read zero and are answered with an error.
   logic [31:0] rdata;

   always_comb begin
      rdata = 32'h0000_0000;
      if (sel_strap) begin
         rdata[N-1:0] = straps;
      end else if (sel_decode) begin
         rdata[`SPBC_DEC_LDO]                       = ldo_sel;
         rdata[`SPBC_DEC_BOOT_HI:`SPBC_DEC_BOOT_LO] = boot;
         rdata[`SPBC_DEC_LOG]                       = straps[`SPBC_BIT_LOG];
         rdata[`SPBC_DEC_SAMPLE]                    = smp_rise;
         rdata[`SPBC_DEC_OUTPUT]                    = out_rise;
         rdata[`SPBC_DEC_CAPTURED]                  = captured;
      end else if (sel_ovr) begin
         rdata[4:0] = override_r;
      end
   end

   // Read data is launched in the setup cycle so that it stands through the
   // access phase, in which the master takes it.
   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         prdata_out <= 32'h0000_0000;
      end else if (psel_in && !penable_in) begin
         prdata_out <= pwrite_in ? 32'h0000_0000 : rdata;
      end
   end

   // Ready and error stand for exactly the access phase: zero wait states.
   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else if (psel_in && !penable_in) begin
         pready_out  <= 1'b1;
         pslverr_out <= !addr_ok;
      end else begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end
   end

endmodule : spbc_top

/* File: tb/spbc_checker.sv */
// Purpose: Port-level assertions for the strap capture block.
// Assumes: APB master keeps the setup then access order.
// Notes:   Bound to every spbc_top instance.
`timescale 1ns/1ps
`include "spbc_consts.svh"

module spbc_checker #(
   parameter int N = 5
) (
   input wire logic         clock_in,
   input wire logic         nrst_in,
   input wire logic         module_enable_in,
   input wire logic [N-1:0] func_out_in,
   input wire logic [N-1:0] func_oe_in,
   input wire logic [N-1:0] pull_up_en_out,
   input wire logic [N-1:0] pull_dn_en_out,
   input wire logic [N-1:0] pad_out,
   input wire logic [N-1:0] pad_oe_out,
   input wire logic         boot_flash_out,
   input wire logic         boot_download_out,
   input wire logic         boot_log_tx_line_en_out,
   input wire logic         sdio_sample_rise_out,
   input wire logic         config_valid_out,
   input wire logic         psel_in,
   input wire logic         penable_in,
   input wire logic         pwrite_in,
   input wire logic [11:0]  paddr_in,
   input wire logic [31:0]  prdata_out,
   input wire logic         pready_out,
   input wire logic         pslverr_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!nrst_in);

   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   sequence s_done;
      psel_in && penable_in && pready_out;
   endsequence
   sequence s_held;
      config_valid_out && $past(config_valid_out);
   endsequence

   a_pull_level: assert property ((pull_up_en_out != 5'h00) |->
      (pull_up_en_out == `SPBC_PULL_DEFAULT) && (pull_dn_en_out == ~`SPBC_PULL_DEFAULT))
      else $error("pull enables differ from the defaults");
   a_pull_clear: assert property (config_valid_out |->
      (pull_up_en_out == 5'h00) && (pull_dn_en_out == 5'h00))
      else $error("pulls still on after boot");
   a_held_stable: assert property (s_held |->
      $stable({boot_flash_out, boot_download_out, boot_log_tx_line_en_out}))
      else $error("captured strap outputs changed");
   a_boot_excl: assert property (boot_flash_out |-> !boot_download_out)
      else $error("both boot modes set");
   a_log_sample: assert property ($rose(config_valid_out) |->
      sdio_sample_rise_out == boot_log_tx_line_en_out)
      else $error("sample edge not from the shared strap");
   a_enable_gate: assert property (!module_enable_in |=> !config_valid_out)
      else $error("valid while disabled");
   a_pad_follow: assert property (s_held |->
      (pad_out == $past(func_out_in)) && (pad_oe_out == $past(func_oe_in)))
      else $error("pads do not follow the function drive");
   a_apb_answer: assert property (s_setup |=> pready_out)
      else $error("no ready in the access phase");
   a_apb_unmapped: assert property (s_done ##0 (paddr_in > `SPBC_OFS_OVERRIDE) |->
      pslverr_out && (prdata_out == 32'h0000_0000))
      else $error("unmapped access not refused");
   a_strap_read: assert property (s_done ##0 (!pwrite_in && config_valid_out &&
      (paddr_in == `SPBC_OFS_STRAP)) |->
      (prdata_out[`SPBC_BIT_LOG] == boot_log_tx_line_en_out) &&
      (prdata_out[`SPBC_BIT_BOOT] == boot_flash_out))
      else $error("strap register disagrees with outputs");
endmodule : spbc_checker

bind spbc_top spbc_checker #(.N(N)) u_checker (.clock_in, .nrst_in, .module_enable_in,
   .func_out_in, .func_oe_in, .pull_up_en_out, .pull_dn_en_out, .pad_out, .pad_oe_out,
   .boot_flash_out, .boot_download_out, .boot_log_tx_line_en_out, .sdio_sample_rise_out,
   .config_valid_out, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
   .pready_out, .pslverr_out);

/* File: tb/spbc_strap_host.sv */
// Purpose: Board and host model that sets the strap pin levels.
// Assumes: Order of bits ldo, boot, qualify, log, sdio.
// Notes:   A pin with no driver and no pull toggles every cycle.
`timescale 1ns/1ps

module spbc_strap_host (
   // Clock and host control
   input  wire logic       clock_in,
   input  wire logic       hold_in,
   input  wire logic [4:0] level_in,
   // Device pad side
   input  wire logic [4:0] pull_up_en_in,
   input  wire logic [4:0] pull_dn_en_in,
   input  wire logic [4:0] pad_in,
   input  wire logic [4:0] pad_oe_in,
   // Pin levels
   output logic      [4:0] pins_out
);
   logic [4:0] float_r = 5'h15;

   always_ff @(posedge clock_in) begin
      float_r <= ~float_r;
   end

   // The host drives only while told to hold, then lets go.
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pins_out[i] = hold_in ? level_in[i] : pad_oe_in[i] ? pad_in[i] :
            pull_up_en_in[i] ? 1'b1 : pull_dn_en_in[i] ? 1'b0 : float_r[i];
      end
   end
endmodule : spbc_strap_host

/* File: tb/strap_pin_boot_config_tb_top.sv */
// Purpose: Self-checking bench for the strap capture block.
// Assumes: Zero-wait APB slave, one clock.
// Notes:   Each boot pass resets the block with a new strap pattern.
`timescale 1ns/1ps
`include "spbc_consts.svh"

module strap_pin_boot_config_tb_top;
   logic        clock_in = 1'b0;
   logic        nrst_in  = 1'b0;
   logic        en = 1'b0, hold = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [4:0]  lvl = 5'h00, fo = 5'h00, foe = 5'h00;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire  [4:0]  pins, pu, pd, pad, poe;
   wire  [31:0] prdata;
   wire         ldo, fl, dl, lg, sr, orr, vld, prdy, perr;
   int          miscompares = 0, n_tests = 0, cyc = 0;

   always #5 clock_in = ~clock_in;

   spbc_top u_dut (.clock_in(clock_in), .nrst_in(nrst_in), .module_enable_in(en),
      .ldo_voltage_strap_in(pins[0]), .boot_select_strap_in(pins[1]),
      .download_qualify_strap_in(pins[2]), .log_and_timing_strap_in(pins[3]),
      .sdio_timing_strap_in(pins[4]), .func_out_in(fo), .func_oe_in(foe),
      .pull_up_en_out(pu), .pull_dn_en_out(pd), .pad_out(pad), .pad_oe_out(poe),
      .ldo_1v8_sel_out(ldo), .boot_flash_out(fl), .boot_download_out(dl),
      .boot_log_tx_line_en_out(lg), .sdio_sample_rise_out(sr), .sdio_output_rise_out(orr),
      .config_valid_out(vld), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata),
      .pready_out(prdy), .pslverr_out(perr));

   spbc_strap_host u_host (.clock_in(clock_in), .hold_in(hold), .level_in(lvl),
      .pull_up_en_in(pu), .pull_dn_en_in(pd), .pad_in(pad), .pad_oe_in(poe),
      .pins_out(pins));

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clock_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      @(posedge clock_in);
      while (prdy !== 1'b1) @(posedge clock_in);
      r = prdata;
      e = perr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [31:0] dec(input logic [4:0] s);
      logic [1:0] b;
      b = s[1] ? spbc_pkg::SPBC_BOOT_FLASH : s[2] ? spbc_pkg::SPBC_BOOT_UNDEF
                                                 : spbc_pkg::SPBC_BOOT_DOWNLOAD;
      return {25'h0, 1'b1, s[4], s[3], s[3], b, s[0]};
   endfunction : dec

   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         end_sim();
      end
   end

   initial begin
      logic [4:0]  pat [4];
      logic [31:0] r;
      logic        e;
      pat = '{5'h1A, 5'h05, 5'h10, 5'h09};
      for (int k = 0; k < 4; k++) begin
         @(posedge clock_in);
         nrst_in <= 1'b0;
         en <= 1'b0;
         hold <= (k != 0);
         lvl <= pat[k];
         repeat (3) @(posedge clock_in);
         chk("pull_up", 32'h1A, {27'h0, pu});
         chk("pull_dn", 32'h05, {27'h0, pd});
         nrst_in <= 1'b1;
         if (k == 0) begin
            repeat (6) @(posedge clock_in);
            chk("early_valid", 32'h0, {31'h0, vld});
         end
         en <= 1'b1;
         while (vld !== 1'b1) @(posedge clock_in);
         @(posedge clock_in);
         chk("decoded", {25'h0, pat[k][0], pat[k][1], !pat[k][1] && !pat[k][2], pat[k][3],
             pat[k][3], pat[k][4], 1'b1}, {25'h0, ldo, fl, dl, lg, sr, orr, vld});
         apb(1'b0, `SPBC_OFS_STRAP, 32'h0, r, e);
         chk("strap_reg", {27'h0, pat[k]}, r);
         hold <= 1'b0;
         apb(1'b1, `SPBC_OFS_STRAP, 32'h0, r, e);
         repeat (4) @(posedge clock_in);
         apb(1'b0, `SPBC_OFS_STRAP, 32'h0, r, e);
         chk("strap_held", {27'h0, pat[k]}, r);
         apb(1'b0, `SPBC_OFS_DECODE, 32'h0, r, e);
         chk("decode_reg", dec(pat[k]), r);
      end
      apb(1'b1, `SPBC_OFS_OVERRIDE, 32'h15, r, e);
      repeat (2) @(posedge clock_in);
      chk("override_out", 32'h05, {28'h0, ldo, lg, sr, orr});
      apb(1'b0, `SPBC_OFS_OVERRIDE, 32'h0, r, e);
      chk("override_reg", 32'h15, r);
      apb(1'b1, `SPBC_OFS_OVERRIDE, 32'h0, r, e);
      repeat (2) @(posedge clock_in);
      chk("override_off", 32'h0E, {28'h0, ldo, lg, sr, orr});
      apb(1'b0, 12'h010, 32'h0, r, e);
      chk("unmapped", 32'h1, {r[30:0], e});
      fo <= 5'h0A;
      foe <= 5'h1F;
      repeat (2) @(posedge clock_in);
      chk("pads", 32'h15F, {22'h0, pad, poe});
      en <= 1'b0;
      repeat (2) @(posedge clock_in);
      chk("disabled", 32'h0, {31'h0, vld});
      end_sim();
   end
endmodule : strap_pin_boot_config_tb_top
